/* File: inc/isd_defines.vh */
// Address ranges, masks and strap reset values for the IDE select decode
`ifndef ISD_DEFINES_VH
`define ISD_DEFINES_VH

`define ISD_ADDR_W          10
`define ISD_PRI_TASK_BASE   10'h1f0
`define ISD_SEC_TASK_BASE   10'h170
`define ISD_TASK_MASK       10'h3f8
`define ISD_PRI_CTRL_BASE   10'h3f6
`define ISD_SEC_CTRL_BASE   10'h376
`define ISD_CTRL_MASK       10'h3fe
`define ISD_NARROW_BASE     10'h320
`define ISD_NARROW_MASK     10'h3fc
`define ISD_STRAP_RST       1'h0
`define ISD_SERIAL_RST      2'h0

`endif

/* File: verilog/isd_range_match.v */
// Masked address comparator used for every decoded window
`timescale 1ns/100ps
module isd_range_match #(
  parameter AW = 10
) (
  // Address and window
  input  wire [AW-1:0] addr,
  input  wire [AW-1:0] base,
  input  wire [AW-1:0] mask,
  // Result
  output wire          hit
);

  // Compare only bits kept by the mask
  assign hit = ((addr & mask) == (base & mask));

endmodule

/* File: verilog/isd_select_decode.v */
// IDE chip select and byte enable decode with adapter strap capture
`timescale 1ns/100ps
`include "isd_defines.vh"
module isd_select_decode #(
  parameter AW = `ISD_ADDR_W
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          rst_b,
  // Host I/O cycle
  input  wire [AW-1:0] host_addr,
  input  wire          host_io_cycle,
  input  wire          host_dma_ack,
  // Configuration
  input  wire          ide_enable,
  input  wire          wide_style,
  input  wire          secondary_set,
  input  wire          adapter_mode,
  // Drive side inputs
  input  wire          wide_transfer_indicator_n,
  // Strap inputs shared with output pins
  input  wire          ide_address_strap,
  input  wire          floppy_address_strap,
  input  wire          serial_addr_strap_hi,
  input  wire          serial_addr_strap_lo,
  // Strobes to the drive
  output reg           ide_low_byte_enable_n,
  output reg           ide_high_byte_enable_n,
  output reg           drive_task_file_select_n,
  output reg           drive_control_block_select_n,
  output wire          wide_transfer_request_n,
  // Latched strap settings
  output reg           ide_addr_ctrl,
  output reg           floppy_addr_ctrl,
  output reg  [1:0]    serial_addr_sel
);

  // Synchronised pin inputs
  reg        ind_s1_ff;
  reg        ind_s2_ff;
  reg  [3:0] strap_s1_ff;
  reg  [3:0] strap_s2_ff;
  reg        dma_s1_ff;
  reg        dma_s2_ff;
  // Decoder outputs
  wire       pri_task_hit;
  wire       sec_task_hit;
  wire       pri_ctrl_hit;
  wire       sec_ctrl_hit;
  wire       narrow_hit;
  // Next values
  reg        nxt_low_n;
  reg        nxt_high_n;
  reg        nxt_task_n;
  reg        nxt_ctrl_n;
  reg        task_hit;
  reg        ctrl_hit;
  reg        cycle_live;

  // Two-flop synchronisers for pins
  always @(posedge mclk) begin
    if (!rst_b) begin
      ind_s1_ff   <= 1'h1;
      ind_s2_ff   <= 1'h1;
      dma_s1_ff   <= 1'h0;
      dma_s2_ff   <= 1'h0;
    end else begin
      ind_s1_ff   <= wide_transfer_indicator_n;
      ind_s2_ff   <= ind_s1_ff;
      dma_s1_ff   <= host_dma_ack;
      dma_s2_ff   <= dma_s1_ff;
    end
  end

  // Strap synchronisers run during reset too, so the sample is clean
  always @(posedge mclk) begin
    strap_s1_ff <= {ide_address_strap, floppy_address_strap,
                    serial_addr_strap_hi, serial_addr_strap_lo};
    strap_s2_ff <= strap_s1_ff;
  end

  // Address windows
  isd_range_match #(.AW(AW)) u_pri_task (
    .addr (host_addr),
    .base (`ISD_PRI_TASK_BASE),
    .mask (`ISD_TASK_MASK),
    .hit  (pri_task_hit)
  );
  isd_range_match #(.AW(AW)) u_sec_task (
    .addr (host_addr),
    .base (`ISD_SEC_TASK_BASE),
    .mask (`ISD_TASK_MASK),
    .hit  (sec_task_hit)
  );
  isd_range_match #(.AW(AW)) u_pri_ctrl (
    .addr (host_addr),
    .base (`ISD_PRI_CTRL_BASE),
    .mask (`ISD_CTRL_MASK),
    .hit  (pri_ctrl_hit)
  );
  isd_range_match #(.AW(AW)) u_sec_ctrl (
    .addr (host_addr),
    .base (`ISD_SEC_CTRL_BASE),
    .mask (`ISD_CTRL_MASK),
    .hit  (sec_ctrl_hit)
  );
  isd_range_match #(.AW(AW)) u_narrow (
    .addr (host_addr),
    .base (`ISD_NARROW_BASE),
    .mask (`ISD_NARROW_MASK),
    .hit  (narrow_hit)
  );

  // Strobe decode; inactive high by default
  always @* begin
    nxt_low_n  = 1'h1;
    nxt_high_n = 1'h1;
    nxt_task_n = 1'h1;
    nxt_ctrl_n = 1'h1;
    task_hit   = 1'h0;
    ctrl_hit   = 1'h0;
    cycle_live = ide_enable & (host_io_cycle | dma_s2_ff);
    if (wide_style) begin
      task_hit = secondary_set ? sec_task_hit : pri_task_hit;
      ctrl_hit = secondary_set ? sec_ctrl_hit : pri_ctrl_hit;
      if (cycle_live) begin
        nxt_low_n  = ~(task_hit | ctrl_hit);
        nxt_task_n = ~task_hit;
        nxt_ctrl_n = ~ctrl_hit;
        // Wide indicator low from drive asks for the high lane
        nxt_high_n = ~(task_hit & ~ind_s2_ff);
      end
    end else begin
      task_hit = narrow_hit;
      ctrl_hit = pri_ctrl_hit;
      if (cycle_live) begin
        nxt_low_n  = ~task_hit;
        nxt_task_n = ~task_hit;
        nxt_ctrl_n = ~ctrl_hit;
      end
      nxt_high_n = 1'h1;
    end
  end

  // Registered strobes
  always @(posedge mclk) begin
    if (!rst_b) begin
      ide_low_byte_enable_n        <= 1'h1;
      ide_high_byte_enable_n       <= 1'h1;
      drive_task_file_select_n     <= 1'h1;
      drive_control_block_select_n <= 1'h1;
    end else begin
      ide_low_byte_enable_n        <= nxt_low_n;
      ide_high_byte_enable_n       <= nxt_high_n;
      drive_task_file_select_n     <= nxt_task_n;
      drive_control_block_select_n <= nxt_ctrl_n;
    end
  end

  // Request for wide cycles mirrors the high lane enable
  assign wide_transfer_request_n = ide_high_byte_enable_n;

  // Strap capture while reset is held in adapter mode, reset values otherwise; held after release
  always @(posedge mclk) begin
    if (!rst_b) begin
      if (adapter_mode) begin
        ide_addr_ctrl    <= strap_s2_ff[3];
        floppy_addr_ctrl <= strap_s2_ff[2];
        serial_addr_sel  <= strap_s2_ff[1:0];
      end else begin
        ide_addr_ctrl    <= `ISD_STRAP_RST;
        floppy_addr_ctrl <= `ISD_STRAP_RST;
        serial_addr_sel  <= `ISD_SERIAL_RST;
      end
    end
  end

endmodule

/* File: verification/isd_drive_model.sv */
// Drive-side model of the wide transfer indicator
`timescale 1ns/100ps
module isd_drive (
  // Clock and request
  input  wire mclk,
  input  wire want_wide,
  // Indicator pin
  output reg  wide_transfer_indicator_n = 1'b1
);
  // Low for wide transfers, high for narrow
  always @(posedge mclk) wide_transfer_indicator_n <= !want_wide;
endmodule

/* File: verification/isd_select_decode_assertions.sv */
// Checker for the IDE strobe decode and strap latches
`timescale 1ns/100ps
module isd_chk #(parameter AW = 10) (
  // Host side
  input wire          mclk, rst_b, host_io_cycle, ide_enable,
  input wire          host_dma_ack,
  input wire          wide_style, secondary_set,
  input wire [AW-1:0] host_addr,
  // Strobes and straps
  input wire          ide_low_byte_enable_n, ide_high_byte_enable_n,
  input wire          drive_task_file_select_n,
  input wire          drive_control_block_select_n,
  input wire          wide_transfer_request_n, ide_addr_ctrl,
  input wire          floppy_addr_ctrl,
  input wire [1:0]    serial_addr_sel
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Live request and window hits
  // DMA acknowledge is a pin: two cycles late, as the decode's two-flop synchroniser gives
  reg dk1 = 1'b0, dk2 = 1'b0;
  always @(posedge mclk) begin
    dk1 <= rst_b & host_dma_ack;
    dk2 <= rst_b & dk1;
  end
  wire go = rst_b & ide_enable & (host_io_cycle | dk2);
  wire tk = host_addr[9:3] == (secondary_set ? 7'h2e : 7'h3e);
  wire ct = host_addr[9:1] == (secondary_set ? 9'h1bb : 9'h1fb);
  wire nt = host_addr[9:2] == 8'hc8;
  wire nc = host_addr[9:1] == 9'h1fb;
  wire [3:0] st = {ide_low_byte_enable_n, ide_high_byte_enable_n,
                   drive_task_file_select_n, drive_control_block_select_n};
  property p_hi; !st[2] |-> $past(wide_style & tk); endproperty
  a_hi: assert property (p_hi) else $error("high enable stray");
  property p_rq; wide_transfer_request_n == st[2]; endproperty
  a_rq: assert property (p_rq) else $error("request mismatch");
  property p_of; !$past(go) |-> &st; endproperty
  a_of: assert property (p_of) else $error("strobe while idle");
  property p_tk; $past(go & wide_style & tk) |-> !st[3] && st[1:0] == 2'b01;
  endproperty
  a_tk: assert property (p_tk) else $error("task select wide");
  property p_ct; $past(go & wide_style & ct) |-> st == 4'b0110; endproperty
  a_ct: assert property (p_ct) else $error("ctrl select wide");
  property p_nt; $past(go & !wide_style & nt) |-> st == 4'b0101; endproperty
  a_nt: assert property (p_nt) else $error("task narrow");
  property p_nc; $past(go & !wide_style & nc) |-> st == 4'b1110; endproperty
  a_nc: assert property (p_nc) else $error("ctrl narrow");
  property p_sp; $past(rst_b) |->
    $stable({ide_addr_ctrl, floppy_addr_ctrl, serial_addr_sel}); endproperty
  a_sp: assert property (p_sp) else $error("strap moved");
endmodule
bind isd_select_decode isd_chk #(.AW(AW)) isd_chk_inst (.*);

/* File: verification/testbench.sv */
// Bench for the IDE select decode
`timescale 1ns/100ps
module testbench;
  // Stimulus and observed pins
  reg        mclk = 0, rst_b = 0, en = 0, cyc = 0, wide = 0, sec = 0;
  reg        want = 0, dma = 0, am = 1;
  reg  [3:0] exp_st = 4'ha;
  reg  [9:0] addr = 10'h000;
  reg  [3:0] sp = 4'ha;
  wire       lo, hi, tf, cb, req, ind, iac, fac;
  wire [1:0] ss;
  wire [8:0] obs = {lo, hi, tf, cb, req, iac, fac, ss};
  integer    bad_count = 0, check_count = 0, cycles = 0;
  isd_drive isd_drive_inst (.mclk(mclk), .want_wide(want),
    .wide_transfer_indicator_n(ind));
  isd_select_decode isd_select_decode_inst (.mclk(mclk), .rst_b(rst_b),
    .host_addr(addr), .host_io_cycle(cyc), .host_dma_ack(dma),
    .ide_enable(en), .wide_style(wide), .secondary_set(sec),
    .adapter_mode(am), .wide_transfer_indicator_n(ind),
    .ide_address_strap(sp[3]), .floppy_address_strap(sp[2]),
    .serial_addr_strap_hi(sp[1]), .serial_addr_strap_lo(sp[0]),
    .ide_low_byte_enable_n(lo), .ide_high_byte_enable_n(hi),
    .drive_task_file_select_n(tf), .drive_control_block_select_n(cb),
    .wide_transfer_request_n(req), .ide_addr_ctrl(iac),
    .floppy_addr_ctrl(fac), .serial_addr_sel(ss));
  // Clock and hang guard
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 400) begin
      bad_count = bad_count + 1;
      conclude;
    end
  end
  task conclude;
    begin
      $display("bad %0d checks %0d", bad_count, check_count);
      if (bad_count == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Access with {en,cyc,wide,sec,want}, expect {lo,hi,tf,cb,req}
  task acc(input [4:0] c, input [9:0] a, input [4:0] e);
    begin
      @(negedge mclk);
      {en, cyc, wide, sec, want} = c;
      addr = a;
      repeat (5) @(negedge mclk);
      check_count = check_count + 1;
      if (obs !== {e, exp_st}) begin
        bad_count = bad_count + 1;
        $display("BAD %0t addr %h got %b", $time, a, obs);
      end
    end
  endtask
  // Reset with straps set, then alter them and walk the windows
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1;
    sp = 4'h5;
    acc(5'b11101, 10'h1f0, 5'h02);
    acc(5'b11101, 10'h3f7, 5'h0d);
    acc(5'b11101, 10'h1f8, 5'h1f);
    acc(5'b11101, 10'h170, 5'h1f);
    acc(5'b11100, 10'h1f0, 5'h0b);
    acc(5'b11111, 10'h177, 5'h02);
    acc(5'b11111, 10'h376, 5'h0d);
    acc(5'b11111, 10'h3f6, 5'h1f);
    acc(5'b11001, 10'h320, 5'h0b);
    acc(5'b11001, 10'h323, 5'h0b);
    acc(5'b11001, 10'h324, 5'h1f);
    acc(5'b11001, 10'h3f6, 5'h1d);
    acc(5'b11011, 10'h3f7, 5'h1d);
    dma = 1;
    acc(5'b10001, 10'h321, 5'h0b);
    dma = 0;
    acc(5'b01101, 10'h1f0, 5'h1f);
    // Second reset outside adapter configuration clears the straps
    am = 0;
    rst_b = 0;
    repeat (6) @(negedge mclk);
    rst_b = 1;
    exp_st = 4'h0;
    acc(5'b11101, 10'h1f0, 5'h02);
    conclude;
  end
endmodule
